// ===== hdl/pin_port.sv
// Eight-pin general-purpose port with its two configuration registers.
`timescale 1ns/1ps
`include "pin_port_params.svh"
module pin_port
  import pin_port_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire cfg_req_t cfg_req,
  output cfg_rsp_t cfg_rsp,
  input wire logic eeprom_present_flag,
  input wire logic scl_drive_low,
  input wire logic sda_drive_low,
  output logic scl_in,
  output logic sda_in,
  input wire logic [7:0] pin_in,
  output pin_drive_t pin_drive
);

  localparam logic [7:0] LEVEL_RESET = `PIN_LEVEL_RESET;
  localparam logic [7:0] SECONDARY_MASK = `PIN_SECONDARY_MASK;

  logic [7:0] pin_direction_q;
  logic [7:0] pin_level_q;
  logic [7:0] pin_sampled;
  logic [7:0] secondary;
  logic [7:0] readback;
  logic [7:0] wr_allowed;
  logic [7:0] serial_oe;
  logic [7:0] drive_out;
  logic [7:0] drive_oe;
  logic [31:0] rd_word;
  logic hit;
  logic dir_wr;
  logic level_wr;
  cfg_rsp_t rsp_q;

  pin_sync u_sync
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(pin_in),
    .sync_out(pin_sampled)
  );

  // Pins 4 and 5 leave general use once the serial EEPROM is seen.
  always_comb
  begin
    if (eeprom_present_flag)
    begin
      secondary = SECONDARY_MASK;
    end
    else
    begin
      secondary = 8'h00;
    end
  end

  // Only the upper six address bits select the dword; byte enables
  // pick which of the two registers a write reaches.
  always_comb
  begin
    hit = (cfg_req.addr[7:2] == `PIN_DWORD_INDEX);
    dir_wr = cfg_req.wr && hit && cfg_req.be[0];
    level_wr = cfg_req.wr && hit && cfg_req.be[2];
  end

  // Direction register keeps its value even for pins in secondary use,
  // so leaving serial mode restores the earlier setting.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_direction_q <= `PIN_DIRECTION_RESET;
    end
    else if (dir_wr)
    begin
      pin_direction_q <= cfg_req.wdata[7:0];
    end
  end

  // The serial controller only ever pulls its pins low.
  always_comb
  begin
    serial_oe = 8'h00;
    serial_oe[`PIN_SCL_INDEX] = scl_drive_low;
    serial_oe[`PIN_SDA_INDEX] = sda_drive_low;
  end

  genvar i;
  generate
    for (i = 0; i < `PIN_COUNT; i++)
    begin : g_pin
      // A level bit accepts writes only while its pin is a plain output.
      assign wr_allowed[i] = pin_direction_q[i] && !secondary[i];

      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          pin_level_q[i] <= LEVEL_RESET[i];
        end
        else if (level_wr && wr_allowed[i])
        begin
          pin_level_q[i] <= cfg_req.wdata[16 + i];
        end
      end

      // Plain output pins read back their driven value; all others the pin.
      assign readback[i] = wr_allowed[i] ? pin_level_q[i]
                                         : pin_sampled[i];

      // Secondary pins are open-drain; their direction bit is ignored.
      assign drive_oe[i] = secondary[i] ? serial_oe[i]
                                        : pin_direction_q[i];
      assign drive_out[i] = secondary[i] ? 1'b0
                                         : pin_level_q[i];
    end
  endgenerate

  always_comb
  begin
    pin_drive.out = drive_out;
    pin_drive.oe = drive_oe;
  end

  // The serial controller sees the synchronized pin levels.
  assign scl_in = pin_sampled[`PIN_SCL_INDEX];
  assign sda_in = pin_sampled[`PIN_SDA_INDEX];

  // The dword carries direction in its low half and levels in its high
  // half; reserved bytes and unmapped dwords read as zero.
  always_comb
  begin
    if (hit)
    begin
      rd_word = {`PIN_RESERVED_BYTE, readback,
                 `PIN_RESERVED_BYTE, pin_direction_q};
    end
    else
    begin
      rd_word = 32'h0000_0000;
    end
  end

  // A read is answered exactly one cycle after it is taken.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp_q.valid <= 1'b0;
    end
    else
    begin
      rsp_q.valid <= cfg_req.rd;
    end
  end

  // Read data stands until the next read replaces it.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp_q.rdata <= 32'h0000_0000;
    end
    else if (cfg_req.rd)
    begin
      rsp_q.rdata <= rd_word;
    end
  end

  assign cfg_rsp = rsp_q;

endmodule : pin_port

// ===== hdl/pin_port_params.svh
// Constants of the eight-pin general-purpose port.
`ifndef PIN_PORT_PARAMS_SVH
`define PIN_PORT_PARAMS_SVH

`define PIN_DIRECTION_OFFSET 8'hb4
`define PIN_LEVEL_OFFSET 8'hb6
`define PIN_DWORD_INDEX 6'h2d
`define PIN_DIRECTION_RESET 8'h00
`define PIN_LEVEL_RESET 8'h00
`define PIN_RESERVED_BYTE 8'h00
`define PIN_SCL_INDEX 4
`define PIN_SDA_INDEX 5
`define PIN_SECONDARY_MASK 8'h30
`define PIN_COUNT 8

`endif

// ===== hdl/pin_port_pkg.sv
// Types shared by the eight-pin general-purpose port.
package pin_port_pkg;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] rdata;
  } cfg_rsp_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pin_drive_t;

endpackage : pin_port_pkg

// ===== hdl/pin_sync.sv
// Two-stage synchronizer for the port's input pins.
`timescale 1ns/1ps
module pin_sync
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] async_in,
  output logic [7:0] sync_out
);

  logic [7:0] meta_q;
  logic [7:0] sync_q;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= 8'h00;
      sync_q <= 8'h00;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule : pin_sync

// ===== tb/pin_port_assertions.sv
// Port checker.
`timescale 1ns/1ps
module pin_port_assertions
  import pin_port_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire cfg_req_t cfg_req,
  input wire cfg_rsp_t cfg_rsp,
  input wire pin_drive_t pin_drive,
  input wire logic eeprom_present_flag,
  input wire logic scl_drive_low,
  input wire logic sda_drive_low
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_rd; cfg_req.rd |=> cfg_rsp.valid; endproperty
  a_rd: assert property (p_rd) else $error("no reply");
  property p_nv; !cfg_req.rd |=> !cfg_rsp.valid; endproperty
  a_nv: assert property (p_nv) else $error("stray reply");
  property p_dir; cfg_req.wr && cfg_req.be[0] && cfg_req.addr == 8'hb4
    |=> (pin_drive.oe & 8'hcf) == ($past(cfg_req.wdata[7:0]) & 8'hcf);
  endproperty
  a_dir: assert property (p_dir) else $error("bad enable");
  property p_rsv; cfg_rsp.valid |-> (cfg_rsp.rdata & 32'hff00_ff00) == 0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("bad upper");
  property p_soe; eeprom_present_flag |-> pin_drive.oe[4] == scl_drive_low
    && pin_drive.oe[5] == sda_drive_low;
  endproperty
  a_soe: assert property (p_soe) else $error("bad serial enable");
  property p_sout; eeprom_present_flag |-> pin_drive.out[5:4] == 2'b00;
  endproperty
  a_sout: assert property (p_sout) else $error("serial pin high");
endmodule : pin_port_assertions
bind pin_port pin_port_assertions chk_u (.core_clk, .rst_n, .cfg_req,
  .cfg_rsp, .pin_drive, .eeprom_present_flag, .scl_drive_low,
  .sda_drive_low);

// ===== tb/pin_board.sv
// Board model that resolves each pin level.
`timescale 1ns/1ps
module pin_board
  import pin_port_pkg::*;
(
  input wire pin_drive_t drv,
  input wire logic [7:0] ext,
  output logic [7:0] pins
);
  assign pins = (drv.oe & drv.out) | (~drv.oe & ext);
endmodule : pin_board

// ===== tb/pin_port_tb.sv
// Bench for the eight-pin port.
`timescale 1ns/1ps
module pin_port_tb;
  import pin_port_pkg::*;
  logic core_clk = 0, rst_n = 0, eep = 0;
  logic scl_lo = 0, sda_lo = 0, scl_i, sda_i;
  logic [7:0] ext = 8'h3c, pins;
  cfg_req_t req = '0;
  cfg_rsp_t rsp;
  pin_drive_t drv;
  int error_cnt = 0, comparisons = 0;
  pin_port dut_u (.core_clk, .rst_n, .cfg_req(req), .cfg_rsp(rsp),
    .eeprom_present_flag(eep), .scl_drive_low(scl_lo),
    .sda_drive_low(sda_lo), .scl_in(scl_i), .sda_in(sda_i),
    .pin_in(pins), .pin_drive(drv));
  pin_board brd_u (.drv, .ext, .pins);
  initial forever #4 core_clk = ~core_clk;
  task chk(logic [32:0] s, e);
    comparisons++;
    if (s !== e)
    begin
      error_cnt++;
      $display("Error %0t %h %h", $time, s, e);
    end
  endtask : chk
  task acc(logic [8:0] a, logic [3:0] b, logic [31:0] d);
    @(posedge core_clk) req <= '{~a[8], a[8], a[7:0], b, d};
    @(posedge core_clk) req <= '0;
    @(negedge core_clk);
  endtask : acc
  task t_out;
    acc(9'hb4, 4'hf, 0);
    chk(rsp, 33'h1_003c_0000);
    acc(9'h1b4, 4'h3, 32'hffff);
    acc(9'h1b4, 4'h4, 32'ha5_0000);
    chk(drv, 16'ha5ff);
    acc(9'hb4, 4'hf, 0);
    chk(rsp, 33'h1_00a5_00ff);
  endtask : t_out
  task t_in;
    acc(9'h1b4, 4'h1, 32'h0f);
    acc(9'h1b4, 4'h4, 32'hff_0000);
    acc(9'hb4, 4'hf, 0);
    chk(rsp, 33'h1_003f_000f);
    acc(9'hb0, 4'hf, 0);
    chk(rsp, 33'h1_0000_0000);
  endtask : t_in
  task t_sec;
    @(posedge core_clk) eep <= 1;
    acc(9'h1b4, 4'h1, 32'hff);
    acc(9'h1b4, 4'h4, 0);
    chk(drv, 16'h00cf);
    acc(9'hb4, 4'hf, 0);
    chk(rsp, 33'h1_0030_00ff);
    @(posedge core_clk) scl_lo <= 1;
    @(negedge core_clk);
    chk(drv, 16'h00df);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk(scl_i, 0);
    chk(sda_i, 1);
    acc(9'hb4, 4'hf, 0);
    chk(rsp, 33'h1_0020_00ff);
  endtask : t_sec
  task finish_test;
    $display("errors %0d checks %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1;
    repeat (2) @(posedge core_clk);
    t_out;
    t_in;
    t_sec;
    finish_test;
  end
  initial
  begin
    #2000;
    error_cnt++;
    finish_test;
  end
endmodule : pin_port_tb
